// *** pkg/aphp_if.sv ***
// pins between host and device of the parallel host port
`timescale 1ns/1ps
`default_nettype none
interface aphp_if #(
   parameter int ADDR_W = 7,
   parameter int DATA_W = 8
);
   logic [ADDR_W-1:0] addr;
   logic              chip_select_n;
   logic              read_write;
   logic              read_strobe_n;
   logic              write_strobe_n;
   logic [DATA_W-1:0] host_data;
   logic              host_data_oe;
   logic [DATA_W-1:0] dev_data;
   logic              dev_data_oe;
   logic              dev_ready;
   logic              dev_ready_oe;
   logic [DATA_W-1:0] data_bus;
   logic              ready_pin;

   // bus resolution; an undriven line reads low
   assign data_bus  = dev_data_oe ? dev_data : (host_data_oe ? host_data : '0);
   assign ready_pin = dev_ready_oe ? dev_ready : 1'b0;

   modport device (
      input  addr, chip_select_n, read_write, read_strobe_n, write_strobe_n, data_bus,
      output dev_data, dev_data_oe, dev_ready, dev_ready_oe
   );
   modport host (
      input  data_bus, ready_pin,
      output addr, chip_select_n, read_write, read_strobe_n, write_strobe_n, host_data, host_data_oe
   );
endinterface
`default_nettype wire

// *** pkg/aphp_map.svh ***
// timing, select codes and map constants of the parallel host port
`ifndef APHP_MAP_SVH
`define APHP_MAP_SVH

// -----------------------------------------------------------------
// clock and cycle conversion
// -----------------------------------------------------------------
`define APHP_CLK_NS            20
`define APHP_CYC_DN(ns)        (((ns) / `APHP_CLK_NS) < 1 ? 1 : ((ns) / `APHP_CLK_NS))
`define APHP_CYC_UP(ns)        (((ns) + `APHP_CLK_NS - 1) / `APHP_CLK_NS)

// -----------------------------------------------------------------
// device answer times
// -----------------------------------------------------------------
`define APHP_DIR_RDY_RR_NS     49
`define APHP_DIR_RDY_WR_NS     182
`define APHP_STB_RDY_RR_NS     45
`define APHP_STB_RDY_WR_NS     182
`define APHP_DIR_RR_CYC        `APHP_CYC_DN(`APHP_DIR_RDY_RR_NS)
`define APHP_DIR_WR_CYC        `APHP_CYC_DN(`APHP_DIR_RDY_WR_NS)
`define APHP_STB_RR_CYC        `APHP_CYC_DN(`APHP_STB_RDY_RR_NS)
`define APHP_STB_WR_CYC        `APHP_CYC_DN(`APHP_STB_RDY_WR_NS)

// -----------------------------------------------------------------
// host spacing between accesses
// -----------------------------------------------------------------
`define APHP_GAP_WR_NS         160
`define APHP_GAP_RD_NS         15
`define APHP_GAP_WR_CYC        `APHP_CYC_UP(`APHP_GAP_WR_NS)
`define APHP_GAP_RD_CYC        `APHP_CYC_UP(`APHP_GAP_RD_NS)

// -----------------------------------------------------------------
// select codes and mode register
// -----------------------------------------------------------------
`define APHP_SEL_DIRLINE       3'h4
`define APHP_SEL_STROBE        3'h3
`define APHP_MODE_REG_ADDR     7'h7F
`define APHP_CNT_W             4

`endif

// *** pkg/aphp_pkg.sv ***
// types of the parallel host port
`default_nettype none
package aphp_pkg;

   typedef enum logic [1:0] {APHP_MODE_OFF, APHP_MODE_DIRLINE, APHP_MODE_STROBE} aphp_mode_t;

endpackage
`default_nettype wire

// *** src/aphp_device.sv ***
// device end of the parallel host port
`timescale 1ns/1ps
`default_nettype none
`include "aphp_map.svh"
module aphp_device #(
   parameter int ADDR_W = 7,
   parameter int DATA_W = 8
) (
   // clock and reset
   input  wire logic               sys_clk,
   input  wire logic               rst_n,
   // host pins
   aphp_if.device                  bus,
   input  wire logic [2:0]         host_mode_select,
   // register core side
   output logic [ADDR_W-1:0]       core_addr,
   output logic [DATA_W-1:0]       core_wdata,
   output logic                    core_wr,
   output logic                    core_rd,
   input  wire logic [DATA_W-1:0]  core_rdata,
   output aphp_pkg::aphp_mode_t    mode
);
   import aphp_pkg::*;

   localparam int PIN_W = ADDR_W + DATA_W + 4;

   typedef enum logic [1:0] {APHP_D_IDLE, APHP_D_BUSY, APHP_D_HOLD} aphp_dstate_t;

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   function automatic aphp_mode_t aphp_decode(input logic [2:0] code);
      aphp_mode_t m;
      m = APHP_MODE_OFF;
      if (code == `APHP_SEL_DIRLINE)
         m = APHP_MODE_DIRLINE;
      else if (code == `APHP_SEL_STROBE)
         m = APHP_MODE_STROBE;
      return m;
   endfunction

   function automatic logic [`APHP_CNT_W-1:0] aphp_busy_len(input aphp_mode_t m, input logic after_wr);
      logic [`APHP_CNT_W-1:0] n;
      n = `APHP_CNT_W'(`APHP_DIR_RR_CYC);
      if (m == APHP_MODE_STROBE)
         n = after_wr ? `APHP_CNT_W'(`APHP_STB_WR_CYC) : `APHP_CNT_W'(`APHP_STB_RR_CYC);
      else if (after_wr)
         n = `APHP_CNT_W'(`APHP_DIR_WR_CYC);
      return n;
   endfunction

   // -----------------------------------------------------------------
   // pin synchronisers
   // -----------------------------------------------------------------
   logic [PIN_W-1:0] pin_meta_r;
   logic [PIN_W-1:0] pin_sync_r;
   logic [2:0]       sel_meta_r;
   logic [2:0]       sel_sync_r;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_meta_r <= {4'hF, {(ADDR_W + DATA_W){1'b0}}};
         pin_sync_r <= {4'hF, {(ADDR_W + DATA_W){1'b0}}};
         sel_meta_r <= 3'h0;
         sel_sync_r <= 3'h0;
      end
      else
      begin
         pin_meta_r <= {bus.chip_select_n, bus.read_write, bus.read_strobe_n, bus.write_strobe_n,
                        bus.addr, bus.data_bus};
         pin_sync_r <= pin_meta_r;
         sel_meta_r <= host_mode_select;
         sel_sync_r <= sel_meta_r;
      end
   end

   logic              cs_n_s;
   logic              rw_s;
   logic              rd_n_s;
   logic              wr_n_s;
   logic [ADDR_W-1:0] addr_s;
   logic [DATA_W-1:0] data_s;

   assign {cs_n_s, rw_s, rd_n_s, wr_n_s, addr_s, data_s} = pin_sync_r;

   // -----------------------------------------------------------------
   // access decode per style
   // -----------------------------------------------------------------
   logic active;
   logic is_read;

   always_comb
   begin
      active  = 1'b0;
      is_read = 1'b0;
      unique case (mode)
         APHP_MODE_DIRLINE:
         begin
            active  = !cs_n_s;
            is_read = rw_s;
         end
         APHP_MODE_STROBE:
         begin
            active  = !cs_n_s && (!rd_n_s || !wr_n_s);
            is_read = !rd_n_s;
         end
         APHP_MODE_OFF:
         begin
            active  = 1'b0;
            is_read = 1'b0;
         end
      endcase
   end

   // -----------------------------------------------------------------
   // access sequencer
   // -----------------------------------------------------------------
   aphp_dstate_t           state_r;
   aphp_dstate_t           state_nxt;
   logic [`APHP_CNT_W-1:0] cnt_r;
   logic                   op_read_r;
   logic                   last_wr_r;
   logic                   fetch_r;

   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         APHP_D_IDLE:
            if (active)
               state_nxt = APHP_D_BUSY;
         APHP_D_BUSY:
            if (cnt_r == `APHP_CNT_W'(1))
               state_nxt = APHP_D_HOLD;
         APHP_D_HOLD:
            if (!active)
               state_nxt = APHP_D_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r   <= APHP_D_IDLE;
         cnt_r     <= '0;
         op_read_r <= 1'b0;
         last_wr_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         if (state_r == APHP_D_IDLE && active)
         begin
            op_read_r <= is_read;
            cnt_r     <= aphp_busy_len(mode, last_wr_r);
         end
         else if (state_r == APHP_D_BUSY)
            cnt_r <= cnt_r - `APHP_CNT_W'(1);
         if (state_r == APHP_D_HOLD && !active)
            last_wr_r <= !op_read_r;
      end
   end

   // -----------------------------------------------------------------
   // register core strobes and read data
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         core_addr  <= '0;
         core_wdata <= '0;
         core_wr    <= 1'b0;
         core_rd    <= 1'b0;
         fetch_r    <= 1'b0;
         bus.dev_data <= '0;
      end
      else
      begin
         core_wr <= 1'b0;
         core_rd <= 1'b0;
         fetch_r <= core_rd;
         if (state_r == APHP_D_IDLE && active)
         begin
            core_addr  <= addr_s;
            core_wdata <= data_s;
            core_wr    <= !is_read;
            core_rd    <= is_read;
         end
         if (fetch_r)
            bus.dev_data <= core_rdata;
      end
   end

   // -----------------------------------------------------------------
   // style selection
   // -----------------------------------------------------------------
   logic [1:0] strap_cnt_r;
   aphp_mode_t pend_mode_r;
   logic       pend_r;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         strap_cnt_r <= 2'h0;
         mode        <= APHP_MODE_OFF;
         pend_mode_r <= APHP_MODE_OFF;
         pend_r      <= 1'b0;
      end
      else
      begin
         if (strap_cnt_r != 2'h3)
            strap_cnt_r <= strap_cnt_r + 2'h1;
         if (strap_cnt_r == 2'h2)
            mode <= aphp_decode(sel_sync_r);
         if (core_wr && core_addr == `APHP_MODE_REG_ADDR)
         begin
            pend_mode_r <= aphp_decode(core_wdata[2:0]);
            pend_r      <= 1'b1;
         end
         else if (pend_r && state_r == APHP_D_IDLE && !active)
         begin
            mode   <= pend_mode_r;
            pend_r <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // ready and data drivers
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bus.dev_ready    <= 1'b0;
         bus.dev_ready_oe <= 1'b0;
         bus.dev_data_oe  <= 1'b0;
      end
      else
      begin
         // direction style: high while busy; strobe style: low while busy
         if (mode == APHP_MODE_STROBE)
            bus.dev_ready <= state_nxt != APHP_D_BUSY;
         else
            bus.dev_ready <= state_nxt == APHP_D_BUSY;
         bus.dev_ready_oe <= mode != APHP_MODE_OFF && !cs_n_s;
         bus.dev_data_oe  <= state_nxt == APHP_D_HOLD && op_read_r && !cs_n_s;
      end
   end

endmodule
`default_nettype wire

// *** src/aphp_host.sv ***
// host end of the parallel host port
`timescale 1ns/1ps
`default_nettype none
`include "aphp_map.svh"
module aphp_host #(
   parameter int ADDR_W = 7,
   parameter int DATA_W = 8
) (
   // clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 rst_n,
   // device pins
   aphp_if.host                      bus,
   // user request side
   input  wire aphp_pkg::aphp_mode_t host_style,
   input  wire logic                 req,
   input  wire logic                 req_write,
   input  wire logic [ADDR_W-1:0]    req_addr,
   input  wire logic [DATA_W-1:0]    req_wdata,
   output logic                      busy,
   output logic                      done,
   output logic [DATA_W-1:0]         rdata
);
   import aphp_pkg::*;

   typedef enum logic [2:0] {APHP_H_IDLE, APHP_H_SETUP, APHP_H_WAIT, APHP_H_END, APHP_H_GAP} aphp_hstate_t;

   // -----------------------------------------------------------------
   // pin synchronisers
   // -----------------------------------------------------------------
   logic [DATA_W:0] in_meta_r;
   logic [DATA_W:0] in_sync_r;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         in_meta_r <= '0;
         in_sync_r <= '0;
      end
      else
      begin
         in_meta_r <= {bus.ready_pin, bus.data_bus};
         in_sync_r <= in_meta_r;
      end
   end

   // -----------------------------------------------------------------
   // access sequencer
   // -----------------------------------------------------------------
   aphp_hstate_t           state_r;
   aphp_mode_t             style_r;
   logic                   wr_r;
   logic                   seen_r;
   logic [`APHP_CNT_W-1:0] gap_r;
   logic                   busy_lvl;

   assign busy_lvl = (style_r == APHP_MODE_STROBE) ? !in_sync_r[DATA_W] : in_sync_r[DATA_W];

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r            <= APHP_H_IDLE;
         style_r            <= APHP_MODE_DIRLINE;
         wr_r               <= 1'b0;
         seen_r             <= 1'b0;
         gap_r              <= '0;
         busy               <= 1'b0;
         done               <= 1'b0;
         rdata              <= '0;
         bus.addr           <= '0;
         bus.chip_select_n  <= 1'b1;
         bus.read_write     <= 1'b1;
         bus.read_strobe_n  <= 1'b1;
         bus.write_strobe_n <= 1'b1;
         bus.host_data      <= '0;
         bus.host_data_oe   <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         unique case (state_r)
            APHP_H_IDLE:
               if (req && host_style != APHP_MODE_OFF)
               begin
                  style_r          <= host_style;
                  wr_r             <= req_write;
                  busy             <= 1'b1;
                  bus.addr         <= req_addr;
                  bus.read_write   <= !req_write;
                  bus.host_data    <= req_wdata;
                  bus.host_data_oe <= req_write;
                  state_r          <= APHP_H_SETUP;
               end
            APHP_H_SETUP:
            begin
               bus.chip_select_n <= 1'b0;
               if (style_r == APHP_MODE_STROBE)
               begin
                  bus.read_strobe_n  <= wr_r;
                  bus.write_strobe_n <= !wr_r;
               end
               seen_r  <= 1'b0;
               state_r <= APHP_H_WAIT;
            end
            APHP_H_WAIT:
            begin
               if (busy_lvl)
                  seen_r <= 1'b1;
               else if (seen_r)
               begin
                  rdata              <= in_sync_r[DATA_W-1:0];
                  bus.read_strobe_n  <= 1'b1;
                  bus.write_strobe_n <= 1'b1;
                  if (style_r == APHP_MODE_DIRLINE)
                     bus.chip_select_n <= 1'b1;
                  state_r <= APHP_H_END;
               end
            end
            APHP_H_END:
            begin
               bus.chip_select_n <= 1'b1;
               bus.host_data_oe  <= 1'b0;
               gap_r   <= wr_r ? `APHP_CNT_W'(`APHP_GAP_WR_CYC) : `APHP_CNT_W'(`APHP_GAP_RD_CYC);
               done    <= 1'b1;
               state_r <= APHP_H_GAP;
            end
            APHP_H_GAP:
            begin
               bus.read_write <= 1'b1;
               if (gap_r <= `APHP_CNT_W'(1))
               begin
                  busy    <= 1'b0;
                  state_r <= APHP_H_IDLE;
               end
               else
                  gap_r <= gap_r - `APHP_CNT_W'(1);
            end
            default:
               state_r <= APHP_H_IDLE;
         endcase
      end
   end

endmodule
`default_nettype wire

// *** tb/aphp_port_chk.sv ***
// assertions on the pins between host and device ends
`timescale 1ns/1ps
`default_nettype none
module aphp_port_chk (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // host drive
   input wire logic chip_select_n,
   input wire logic read_write,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   // device drive
   input wire logic dev_data_oe,
   input wire logic dev_ready_oe,
   input wire logic ready_pin
);
   logic       cur_wr_r;
   logic       prev_wr_r;
   logic [3:0] gap_r;
   logic       dir;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // no strobe low means direction style
   assign dir = read_strobe_n && write_strobe_n;

   // -----------------------------------------------------------------
   // access history
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cur_wr_r  <= 1'h1;
         prev_wr_r <= 1'h1;
      end
      else if ($fell(chip_select_n))
      begin
         cur_wr_r  <= !write_strobe_n || (dir && !read_write);
         prev_wr_r <= cur_wr_r;
      end
   end

   // cycles with select high, saturating
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         gap_r <= 4'hF;
      else if (!chip_select_n)
         gap_r <= 4'h0;
      else if (gap_r != 4'hF)
         gap_r <= gap_r + 4'h1;
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   a_ready_on_select: assert property ($fell(chip_select_n) |-> ##[1:5] dev_ready_oe)
      else $error("ready not driven after select");
   a_bus_released: assert property (chip_select_n [*5] |-> !dev_data_oe && !dev_ready_oe)
      else $error("bus still driven without select");
   a_dir_rr_busy: assert property ($rose(ready_pin) && dir && !chip_select_n && !prev_wr_r |-> ##[1:2] !ready_pin)
      else $error("ready high too long after read");
   a_dir_wr_busy: assert property ($rose(ready_pin) && dir && !chip_select_n |-> ##[1:9] !ready_pin)
      else $error("ready high too long after write");
   a_dir_data_valid: assert property ($fell(ready_pin) && dir && read_write && !chip_select_n |-> dev_data_oe)
      else $error("no read data at completion");
   a_stb_rr_ready: assert property ($fell(chip_select_n) && !dir && !cur_wr_r |-> ##[1:7] ready_pin)
      else $error("ready low too long after read");
   a_stb_wr_ready: assert property ($fell(chip_select_n) && !dir |-> ##[1:14] ready_pin)
      else $error("ready low too long after write");
   a_stb_data_valid: assert property ($rose(ready_pin) && !read_strobe_n |-> dev_data_oe)
      else $error("no read data with ready");
   a_dir_line_stable: assert property (dir && !chip_select_n && !$past(chip_select_n) |-> $stable(read_write))
      else $error("direction changed inside access");
   a_select_held: assert property (dir && $past(dir) && !chip_select_n && ready_pin |=> !chip_select_n)
      else $error("select released before ready dropped");
   a_rstrobe_held: assert property (!read_strobe_n && !ready_pin |=> !read_strobe_n)
      else $error("read strobe released before ready");
   a_strobe_framed: assert property (!read_strobe_n || !write_strobe_n |-> !chip_select_n)
      else $error("strobe outside select");
   a_write_gap: assert property ($fell(chip_select_n) && cur_wr_r |-> gap_r >= 4'h8)
      else $error("access too soon after write");

   c_dir_read: cover property ($fell(ready_pin) && dir && read_write && !chip_select_n);
   c_stb_read: cover property ($rose(ready_pin) && !read_strobe_n);
   c_stb_write: cover property ($rose(ready_pin) && !write_strobe_n);
endmodule
`default_nettype wire

// *** tb/test_async_parallel_host_port.sv ***
// bench joining host and device ends of the parallel host port
`timescale 1ns/1ps
`default_nettype none
module test_async_parallel_host_port;
   import aphp_pkg::*;
   logic       sys_clk;
   logic       rst_n;
   logic [2:0] host_mode_select;
   logic [7:0] core_rdata;
   logic [6:0] core_addr;
   logic [7:0] core_wdata;
   logic       core_wr;
   logic       core_rd;
   aphp_mode_t mode;
   aphp_mode_t host_style;
   logic       req;
   logic       req_write;
   logic [6:0] req_addr;
   logic [7:0] req_wdata;
   logic       busy;
   logic       done;
   logic [7:0] rdata;
   logic [7:0] mem [0:127];
   logic [6:0] wr_addr;
   logic [7:0] wr_data;
   logic       refused;
   int         n_wr;
   int         n_rd;
   int         n_fail;
   int         checks_done;

   aphp_if #(.ADDR_W(7), .DATA_W(8)) pins ();

   aphp_device aphp_device_i (.sys_clk(sys_clk), .rst_n(rst_n), .bus(pins), .host_mode_select(host_mode_select),
      .core_addr(core_addr), .core_wdata(core_wdata), .core_wr(core_wr), .core_rd(core_rd),
      .core_rdata(core_rdata), .mode(mode));
   aphp_host aphp_host_i (.sys_clk(sys_clk), .rst_n(rst_n), .bus(pins), .host_style(host_style), .req(req),
      .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .busy(busy), .done(done),
      .rdata(rdata));
   aphp_port_chk aphp_port_chk_i (.sys_clk(sys_clk), .rst_n(rst_n), .chip_select_n(pins.chip_select_n),
      .read_write(pins.read_write), .read_strobe_n(pins.read_strobe_n), .write_strobe_n(pins.write_strobe_n),
      .dev_data_oe(pins.dev_data_oe), .dev_ready_oe(pins.dev_ready_oe), .ready_pin(pins.ready_pin));

   always #10 sys_clk = ~sys_clk;

   // -----------------------------------------------------------------
   // register core stand-in
   // -----------------------------------------------------------------
   always @(posedge sys_clk)
   begin
      if (core_wr === 1'h1)
      begin
         mem[core_addr] <= core_wdata;
         wr_addr <= core_addr;
         wr_data <= core_wdata;
         n_wr <= n_wr + 1;
      end
      if (core_rd === 1'h1)
         n_rd <= n_rd + 1;
      core_rdata <= #1 mem[core_addr];
   end

   // -----------------------------------------------------------------
   // tasks
   // -----------------------------------------------------------------
   task automatic check_eq(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("BAD at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic do_reset(input logic [2:0] code);
      host_mode_select = code;
      rst_n = 1'h0;
      repeat (20) @(posedge sys_clk);
      #1;
      rst_n = 1'h1;
      repeat (8) @(posedge sys_clk);
      #1;
   endtask

   function automatic logic [7:0] exp_mode(input logic [2:0] code);
      case (code)
         3'h4: return {6'h00, APHP_MODE_DIRLINE};
         3'h3: return {6'h00, APHP_MODE_STROBE};
         default: return {6'h00, APHP_MODE_OFF};
      endcase
   endfunction

   // one host access; for a read d is the expected data
   task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d);
      int i;
      @(posedge sys_clk);
      #1;
      req = 1'h1;
      req_write = w;
      req_addr = a;
      req_wdata = d;
      @(posedge sys_clk);
      #1;
      req = 1'h0;
      for (i = 0; i < 60 && done !== 1'h1; i++)
      begin
         @(posedge sys_clk);
         #1;
      end
      check_eq({7'h00, done}, 8'h01);
      if (!w)
         check_eq(rdata, d);
      for (i = 0; i < 40 && busy !== 1'h0; i++)
      begin
         @(posedge sys_clk);
         #1;
      end
      check_eq({7'h00, busy}, 8'h00);
   endtask

   // -----------------------------------------------------------------
   // tests
   // -----------------------------------------------------------------
   initial
   begin
      repeat (5000) @(posedge sys_clk);
      n_fail++;
      give_verdict;
   end

   initial
   begin
      int k;
      sys_clk = 1'h0;
      rst_n = 1'h0;
      host_mode_select = 3'h4;
      core_rdata = 8'h00;
      host_style = APHP_MODE_OFF;
      req = 1'h0;
      req_write = 1'h0;
      req_addr = 7'h00;
      req_wdata = 8'h00;
      n_wr = 0;
      n_rd = 0;
      n_fail = 0;
      checks_done = 0;
      for (k = 0; k < 8; k++)
      begin
         do_reset(3'(k));
         check_eq({6'h00, mode}, exp_mode(3'(k)));
      end
      do_reset(3'h4);
      host_style = APHP_MODE_DIRLINE;
      xfer(1'h1, 7'h05, 8'hA1);
      check_eq({1'h0, wr_addr}, 8'h05);
      check_eq(wr_data, 8'hA1);
      xfer(1'h0, 7'h05, 8'hA1);
      xfer(1'h0, 7'h05, 8'hA1);
      xfer(1'h1, 7'h06, 8'h5C);
      xfer(1'h1, 7'h07, 8'h3E);
      xfer(1'h0, 7'h06, 8'h5C);
      xfer(1'h0, 7'h07, 8'h3E);
      check_eq(8'(n_wr), 8'h03);
      // host style off refuses a request
      host_style = APHP_MODE_OFF;
      @(posedge sys_clk);
      #1;
      req = 1'h1;
      @(posedge sys_clk);
      #1;
      req = 1'h0;
      refused = 1'h1;
      repeat (20)
      begin
         @(posedge sys_clk);
         #1;
         if (done !== 1'h0 || pins.chip_select_n !== 1'h1)
            refused = 1'h0;
      end
      check_eq({7'h00, refused}, 8'h01);
      host_style = APHP_MODE_DIRLINE;
      xfer(1'h1, 7'h7F, 8'h03);
      check_eq({6'h00, mode}, exp_mode(3'h3));
      host_style = APHP_MODE_STROBE;
      xfer(1'h1, 7'h10, 8'h99);
      xfer(1'h0, 7'h10, 8'h99);
      xfer(1'h0, 7'h06, 8'h5C);
      xfer(1'h1, 7'h7F, 8'h04);
      check_eq({6'h00, mode}, exp_mode(3'h4));
      host_style = APHP_MODE_DIRLINE;
      xfer(1'h0, 7'h07, 8'h3E);
      // tenth reset with strobe straps
      do_reset(3'h3);
      check_eq({6'h00, mode}, exp_mode(3'h3));
      host_style = APHP_MODE_STROBE;
      xfer(1'h0, 7'h10, 8'h99);
      check_eq(8'(n_rd), 8'h08);
      give_verdict;
   end
endmodule
`default_nettype wire
